// >>> hdl/reset_supervisor_pkg.sv
package reset_supervisor_pkg;

  // register addresses
  localparam logic [7:0] SUPPLY_CTRL_ADDR = 8'hff;
  localparam logic [7:0] RESET_SRC_ADDR = 8'hef;

  // supply_monitor_control fields
  localparam int DIG_MON_EN_BIT = 7;
  localparam int DIG_STATUS_BIT = 6;
  localparam int DIG_WARN_BIT = 5;
  localparam int DIG_IRQ_EN_BIT = 4;
  localparam int BAT_MON_EN_BIT = 3;
  localparam int BAT_STATUS_BIT = 2;
  localparam int BAT_WARN_BIT = 1;
  localparam int BAT_IRQ_EN_BIT = 0;

  // reset_source_register fields
  localparam int RTC_BIT = 7;
  localparam int FLASH_BIT = 6;
  localparam int COMP_BIT = 5;
  localparam int SW_BIT = 4;
  localparam int WDOG_BIT = 3;
  localparam int CLK_BIT = 2;
  localparam int POWER_BIT = 1;
  localparam int PIN_BIT = 0;

  // reset values
  localparam logic DIG_MON_EN_RST = 1'b1;
  localparam logic BAT_MON_EN_RST = 1'b0;
  localparam logic IRQ_EN_RST = 1'b0;
  localparam logic [7:0] POWER_ONLY = 8'h02;

  // timing
  localparam int CLK_PERIOD_NS = 10;
  localparam int CLOCK_LOSS_US = 100;
  localparam int CLOCK_LOSS_CYCLES_DEF = (CLOCK_LOSS_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [3:0] WDOG_DIV_LAST = 4'hb;
  localparam logic [8:0] WDOG_TIMEOUT_TICKS = 9'h100;
  localparam logic [2:0] HOLD_LAST = 3'h3;

  typedef enum logic {ST_RUN, ST_HOLD} sup_state_e;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } bus_req_s;

  typedef struct packed {
    logic dig_above_rst;
    logic dig_above_warn;
    logic bat_above_rst;
    logic bat_above_warn;
  } supply_s;

  typedef struct packed {
    logic write;
    logic read;
    logic fetch;
    logic blocked;
    logic [16:0] addr;
    logic [16:0] lock_addr;
  } flash_req_s;

endpackage

// >>> hdl/reset_source_supervisor.sv
`timescale 1ns/1ps
// Contract
// - supply control bit 7 enables digital monitor, read-write, resets to 1
// - bit 6 reads live digital supply status against the reset threshold
// - bit 5 reads digital early warning against the warning threshold
// - bit 4 enables the digital early-warning interrupt, resets to 0
// - bit 3 enables the battery supply monitor, resets to 0
// - bit 2 reads battery supply status against the reset threshold
// - bit 1 reads battery early warning, 1 when above warning threshold with the battery monitor enabled
// - bit 0 enables the battery early-warning interrupt, resets to 0
// - low external reset pin resets the device in every mode
// - pin reset sets reset source bit 0 on exit
// - clock stuck at one level over 100 us causes a reset
// - reset source bit 2 flags clock-loss reset; writes enable the detector
// - clock-loss reset suppressed in low power; enable state kept
// - bit 5 enables comparator reset when positive input below negative
// - comparator reset works in low power only when also a wake source
// - watchdog enabled at system clock over 12 after any reset
// - watchdog reset suppressed in low power; enable state kept
// - illegal flash access resets the device
// - flash error reset sets reset source bit 6
// - bit 7 enables real-time-clock alarm or oscillator-fail reset, also low power
// - writing 1 to bit 4 forces reset; non-power resets leave pin undriven
// - power and supply-monitor resets drive the reset pin low
// - bit 1 reads 1 after power or supply-monitor reset
// - reset source register sits at address 0xef
module reset_source_supervisor #(
  parameter logic [13:0] CLOCK_LOSS_CYCLES = 14'(reset_supervisor_pkg::CLOCK_LOSS_CYCLES_DEF)
) (
  input wire logic ref_clk_in,
  input wire logic rst_n_in,
  input wire logic ce_in,
  input wire reset_supervisor_pkg::bus_req_s bus_req_in,
  output logic [7:0] rdata_out,
  input wire reset_supervisor_pkg::supply_s supply_in,
  input wire reset_supervisor_pkg::flash_req_s flash_req_in,
  input wire logic ext_rst_n_in,
  output logic rst_pin_out,
  output logic rst_pin_oe_out,
  input wire logic low_power_in,
  input wire logic system_clock_level_in,
  input wire logic comp_out_in,
  input wire logic comp_wake_en_in,
  input wire logic wdog_kick_in,
  input wire logic wdog_disable_in,
  input wire logic rtc_alarm_in,
  input wire logic rtc_osc_fail_in,
  output logic sys_reset_out,
  output logic digital_warn_irq_out,
  output logic battery_warn_irq_out
);
  import reset_supervisor_pkg::*;

  typedef struct packed {
    sup_state_e st;
    logic [7:0] cause;
    logic [7:0] flags;
    logic dig_mon_en;
    logic bat_mon_en;
    logic dig_irq_en;
    logic bat_irq_en;
    logic power_rst_en;
    logic clk_loss_en;
    logic comp_en;
    logic rtc_en;
    logic [13:0] clk_loss_cnt;
    logic clk_level;
    logic [3:0] wdog_div;
    logic [8:0] wdog_cnt;
    logic wdog_en;
    logic [2:0] hold_cnt;
    logic [7:0] rdata;
    logic sys_reset;
    logic pin_oe;
    logic dig_irq;
    logic bat_irq;
  } state_s;

  localparam state_s STATE_RESET = '{
    st: ST_HOLD, cause: POWER_ONLY, flags: 8'h00,
    dig_mon_en: DIG_MON_EN_RST, bat_mon_en: BAT_MON_EN_RST,
    dig_irq_en: IRQ_EN_RST, bat_irq_en: IRQ_EN_RST, power_rst_en: 1'b1,
    clk_loss_en: 1'b0, comp_en: 1'b0, rtc_en: 1'b0,
    clk_loss_cnt: 14'h0000, clk_level: 1'b0, wdog_div: 4'h0, wdog_cnt: 9'h000,
    wdog_en: 1'b1, hold_cnt: 3'h0, rdata: 8'h00, sys_reset: 1'b1,
    pin_oe: 1'b1, dig_irq: 1'b0, bat_irq: 1'b0
  };

  state_s s_q;
  state_s s_d;
  logic power_lvl;
  logic pin_lvl;
  logic wr_ctrl;
  logic wr_src;
  logic [7:0] ev;

  function automatic logic flash_illegal(input flash_req_s f, input logic mon_en);
    logic above;
    above = f.addr > f.lock_addr;
    flash_illegal = (f.write & (above | ~mon_en)) | (f.read & above) | (f.fetch & above) |
                    ((f.write | f.read | f.fetch) & f.blocked);
  endfunction

  function automatic logic [7:0] read_mux(input logic [7:0] addr, input state_s s,
                                          input supply_s sup);
    logic [7:0] v;
    v = 8'h00;
    if (addr == SUPPLY_CTRL_ADDR) begin
      v[DIG_MON_EN_BIT] = s.dig_mon_en;
      v[DIG_STATUS_BIT] = sup.dig_above_rst;
      v[DIG_WARN_BIT] = sup.dig_above_warn;
      v[DIG_IRQ_EN_BIT] = s.dig_irq_en;
      v[BAT_MON_EN_BIT] = s.bat_mon_en;
      // battery comparators are powered down while the monitor is off
      v[BAT_STATUS_BIT] = sup.bat_above_rst & s.bat_mon_en;
      v[BAT_WARN_BIT] = sup.bat_above_warn & s.bat_mon_en;
      v[BAT_IRQ_EN_BIT] = s.bat_irq_en;
    end else if (addr == RESET_SRC_ADDR) begin
      v = s.flags;
    end
    read_mux = v;
  endfunction

  // supply monitors trip only while awake; sleep keeps their enables untouched
  assign power_lvl = ~low_power_in &
                     ((s_q.dig_mon_en & s_q.power_rst_en & ~supply_in.dig_above_rst) |
                      (s_q.bat_mon_en & ~supply_in.bat_above_rst));
  // our own pin drive must not read back as an external reset
  assign pin_lvl = ~ext_rst_n_in & ~s_q.pin_oe;
  assign wr_ctrl = bus_req_in.wr & (bus_req_in.addr == SUPPLY_CTRL_ADDR) & (s_q.st == ST_RUN);
  assign wr_src = bus_req_in.wr & (bus_req_in.addr == RESET_SRC_ADDR) & (s_q.st == ST_RUN);

  always_comb begin
    ev = 8'h00;
    ev[PIN_BIT] = pin_lvl;
    ev[POWER_BIT] = power_lvl;
    ev[CLK_BIT] = s_q.clk_loss_en & ~low_power_in &
                  (s_q.clk_loss_cnt >= CLOCK_LOSS_CYCLES);
    ev[WDOG_BIT] = s_q.wdog_en & ~low_power_in &
                   (s_q.wdog_cnt == WDOG_TIMEOUT_TICKS);
    ev[SW_BIT] = wr_src & bus_req_in.wdata[SW_BIT];
    ev[COMP_BIT] = s_q.comp_en & ~comp_out_in & (~low_power_in | comp_wake_en_in);
    ev[FLASH_BIT] = flash_illegal(flash_req_in, s_q.dig_mon_en);
    ev[RTC_BIT] = s_q.rtc_en & (rtc_alarm_in | rtc_osc_fail_in);
  end

  always_comb begin
    s_d = s_q;
    s_d.rdata = 8'h00;
    if (bus_req_in.rd) begin
      s_d.rdata = read_mux(bus_req_in.addr, s_q, supply_in);
    end
    s_d.dig_irq = s_q.dig_irq_en & s_q.dig_mon_en & ~supply_in.dig_above_warn;
    s_d.bat_irq = s_q.bat_irq_en & s_q.bat_mon_en & ~supply_in.bat_above_warn;
    // clock-loss watch: cycles since the sampled system clock last toggled
    s_d.clk_level = system_clock_level_in;
    if (system_clock_level_in != s_q.clk_level) begin
      s_d.clk_loss_cnt = 14'h0000;
    end else if (s_q.clk_loss_cnt < CLOCK_LOSS_CYCLES) begin
      s_d.clk_loss_cnt = s_q.clk_loss_cnt + 14'h0001;
    end
    // watchdog prescaler freezes in low power so the count resumes on wake
    if (wdog_kick_in) begin
      s_d.wdog_cnt = 9'h000;
      s_d.wdog_div = 4'h0;
    end else if (s_q.wdog_en & ~low_power_in) begin
      if (s_q.wdog_div == WDOG_DIV_LAST) begin
        s_d.wdog_div = 4'h0;
        if (s_q.wdog_cnt != WDOG_TIMEOUT_TICKS) begin
          s_d.wdog_cnt = s_q.wdog_cnt + 9'h001;
        end
      end else begin
        s_d.wdog_div = s_q.wdog_div + 4'h1;
      end
    end
    if (wdog_disable_in) begin
      s_d.wdog_en = 1'b0;
    end
    unique case (s_q.st)
      ST_RUN: begin
        if (wr_ctrl) begin
          s_d.dig_mon_en = bus_req_in.wdata[DIG_MON_EN_BIT];
          s_d.dig_irq_en = bus_req_in.wdata[DIG_IRQ_EN_BIT];
          s_d.bat_mon_en = bus_req_in.wdata[BAT_MON_EN_BIT];
          s_d.bat_irq_en = bus_req_in.wdata[BAT_IRQ_EN_BIT];
        end
        if (wr_src) begin
          s_d.rtc_en = bus_req_in.wdata[RTC_BIT];
          s_d.comp_en = bus_req_in.wdata[COMP_BIT];
          s_d.clk_loss_en = bus_req_in.wdata[CLK_BIT];
          s_d.power_rst_en = bus_req_in.wdata[POWER_BIT];
        end
        if (|ev) begin
          s_d.st = ST_HOLD;
          s_d.cause = ev[POWER_BIT] ? POWER_ONLY : ev;
          s_d.sys_reset = 1'b1;
          s_d.pin_oe = ev[POWER_BIT];
          s_d.hold_cnt = 3'h0;
        end
      end
      ST_HOLD: begin
        // comparator, RTC, clock-loss and interrupt enables held cleared, watchdog held enabled and both counters zeroed while in reset
        s_d.comp_en = 1'b0;
        s_d.rtc_en = 1'b0;
        s_d.clk_loss_en = 1'b0;
        s_d.dig_irq_en = IRQ_EN_RST;
        s_d.bat_irq_en = IRQ_EN_RST;
        s_d.wdog_en = 1'b1;
        s_d.wdog_cnt = 9'h000;
        s_d.wdog_div = 4'h0;
        s_d.clk_loss_cnt = 14'h0000;
        if (s_q.cause[POWER_BIT]) begin
          // monitor enables change only on power-class resets
          s_d.dig_mon_en = DIG_MON_EN_RST;
          s_d.bat_mon_en = BAT_MON_EN_RST;
          s_d.power_rst_en = 1'b1;
        end
        if (power_lvl) begin
          s_d.cause = POWER_ONLY;
          s_d.pin_oe = 1'b1;
          s_d.hold_cnt = 3'h0;
        end else if (pin_lvl) begin
          s_d.hold_cnt = 3'h0;
        end else if (s_q.hold_cnt == HOLD_LAST) begin
          s_d.st = ST_RUN;
          s_d.flags = s_q.cause;
          s_d.sys_reset = 1'b0;
          s_d.pin_oe = 1'b0;
        end else begin
          s_d.hold_cnt = s_q.hold_cnt + 3'h1;
        end
      end
    endcase
  end

  always_ff @(posedge ref_clk_in) begin
    if (!rst_n_in) begin
      s_q <= STATE_RESET;
    end else if (ce_in) begin
      s_q <= s_d;
    end
  end

  assign rdata_out = s_q.rdata;
  assign rst_pin_out = 1'b0;
  assign rst_pin_oe_out = s_q.pin_oe;
  assign sys_reset_out = s_q.sys_reset;
  assign digital_warn_irq_out = s_q.dig_irq;
  assign battery_warn_irq_out = s_q.bat_irq;

  default clocking cb @(posedge ref_clk_in);
  endclocking
  default disable iff (!rst_n_in || !ce_in);

  logic rd_ctrl;
  logic rd_src;
  assign rd_ctrl = bus_req_in.rd && (bus_req_in.addr == SUPPLY_CTRL_ADDR);
  assign rd_src = bus_req_in.rd && (bus_req_in.addr == RESET_SRC_ADDR);

  dig_en_wr_a: assert property (
    wr_ctrl |=> s_q.dig_mon_en == $past(bus_req_in.wdata[DIG_MON_EN_BIT]))
    else $error("digital monitor enable not written");
  dig_status_a: assert property (
    rd_ctrl |=> rdata_out[6] == $past(supply_in.dig_above_rst))
    else $error("digital supply status wrong");
  dig_warn_a: assert property (
    rd_ctrl |=> rdata_out[5] == $past(supply_in.dig_above_warn))
    else $error("digital early warning wrong");
  dig_irq_a: assert property (
    s_q.dig_irq_en && s_q.dig_mon_en && !supply_in.dig_above_warn |=> digital_warn_irq_out)
    else $error("digital warning interrupt missing");
  bat_status_a: assert property (
    rd_ctrl |=> rdata_out[2:1] == ($past({supply_in.bat_above_rst, supply_in.bat_above_warn})
                                   & {2{$past(s_q.bat_mon_en)}}))
    else $error("battery status wrong");
  bat_irq_a: assert property (
    !battery_warn_irq_out ##1 battery_warn_irq_out |-> $past(s_q.bat_irq_en))
    else $error("battery interrupt without enable");
  pin_reset_a: assert property (
    !ext_rst_n_in && !s_q.pin_oe |=> sys_reset_out)
    else $error("pin reset not taken");
  clk_loss_a: assert property (
    s_q.st == ST_RUN && s_q.clk_loss_en && !low_power_in &&
    !power_lvl && s_q.clk_loss_cnt >= CLOCK_LOSS_CYCLES |=> sys_reset_out && !rst_pin_oe_out)
    else $error("clock loss reset missing");
  src_read_a: assert property (
    rd_src |=> rdata_out == $past(s_q.flags))
    else $error("reset source read wrong");
  lp_suppress_a: assert property (
    $rose(sys_reset_out) && $past(low_power_in) |-> !s_q.cause[CLK_BIT] && !s_q.cause[WDOG_BIT])
    else $error("clock or watchdog reset in low power");
  comp_reset_a: assert property (
    s_q.st == ST_RUN && s_q.comp_en && !comp_out_in && !low_power_in |=> sys_reset_out)
    else $error("comparator reset missing");
  wdog_on_a: assert property (
    $fell(sys_reset_out) |-> s_q.wdog_en && s_q.wdog_cnt == 9'h000)
    else $error("watchdog not enabled after reset");
  flash_reset_a: assert property (
    s_q.st == ST_RUN && flash_req_in.write && !s_q.dig_mon_en |=> sys_reset_out)
    else $error("flash write without monitor not reset");
  sw_reset_a: assert property (
    wr_src && bus_req_in.wdata[4] && !power_lvl |=> sys_reset_out && !rst_pin_oe_out)
    else $error("software reset wrong");
  power_pin_a: assert property (
    sys_reset_out && s_q.cause[POWER_BIT] |-> rst_pin_oe_out)
    else $error("power reset leaves pin undriven");
  flag_capture_a: assert property (
    $fell(sys_reset_out) |-> s_q.flags == $past(s_q.cause) &&
                             (!s_q.flags[POWER_BIT] || s_q.flags == 8'h02))
    else $error("reset flags not captured");

  // enable readback and per-source entry; a pending supply fault would take the pin instead
  ctrl_read_a: assert property (
    rd_ctrl |=> rdata_out[DIG_MON_EN_BIT] == $past(s_q.dig_mon_en))
    else $error("digital monitor enable read wrong");
  dig_ie_read_a: assert property (
    rd_ctrl |=> rdata_out[DIG_IRQ_EN_BIT] == $past(s_q.dig_irq_en))
    else $error("digital interrupt enable read wrong");
  dig_irq_off_a: assert property (
    !s_q.dig_irq_en |=> !digital_warn_irq_out)
    else $error("digital interrupt while disabled");
  bat_en_wr_a: assert property (
    wr_ctrl |=> s_q.bat_mon_en == $past(bus_req_in.wdata[BAT_MON_EN_BIT]))
    else $error("battery monitor enable not written");
  bat_ie_read_a: assert property (
    rd_ctrl |=> rdata_out[BAT_IRQ_EN_BIT] == $past(s_q.bat_irq_en))
    else $error("battery interrupt enable read wrong");
  bat_irq_off_a: assert property (
    !s_q.bat_irq_en |=> !battery_warn_irq_out)
    else $error("battery interrupt while disabled");
  pin_hold_a: assert property (
    sys_reset_out && !ext_rst_n_in && !rst_pin_oe_out |=> sys_reset_out)
    else $error("reset released while pin held low");
  clk_en_wr_a: assert property (
    wr_src |=> s_q.clk_loss_en == $past(bus_req_in.wdata[CLK_BIT]))
    else $error("clock-loss enable not written");
  clk_en_keep_a: assert property (
    s_q.st == ST_RUN && low_power_in && !wr_src |=> s_q.clk_loss_en == $past(s_q.clk_loss_en))
    else $error("clock-loss enable lost in low power");
  comp_sleep_a: assert property (
    $rose(sys_reset_out) && $past(low_power_in) && !$past(comp_wake_en_in) |->
    !s_q.cause[COMP_BIT])
    else $error("comparator reset in low power without wake");
  wdog_expire_a: assert property (
    s_q.st == ST_RUN && s_q.wdog_en && !low_power_in && !power_lvl &&
    s_q.wdog_cnt == WDOG_TIMEOUT_TICKS |=> sys_reset_out && !rst_pin_oe_out)
    else $error("watchdog expiry did not reset");
  wdog_freeze_a: assert property (
    s_q.st == ST_RUN && low_power_in && !wdog_kick_in |=> s_q.wdog_cnt == $past(s_q.wdog_cnt))
    else $error("watchdog counted in low power");
  flash_fetch_a: assert property (
    s_q.st == ST_RUN && flash_req_in.fetch &&
    flash_req_in.addr > flash_req_in.lock_addr |=> sys_reset_out)
    else $error("fetch above lock address not reset");
  rtc_reset_a: assert property (
    s_q.st == ST_RUN && s_q.rtc_en && (rtc_alarm_in || rtc_osc_fail_in) |=> sys_reset_out)
    else $error("real-time clock reset missing");
  power_hold_a: assert property (
    power_lvl |=> sys_reset_out && rst_pin_oe_out)
    else $error("supply fault did not hold pin low");
  unmapped_read_a: assert property (
    bus_req_in.rd && !rd_ctrl && !rd_src |=> rdata_out == 8'h00)
    else $error("unmapped read not zero");
  hold_stretch_a: assert property (
    $fell(sys_reset_out) |-> $past(s_q.hold_cnt) == HOLD_LAST)
    else $error("reset released early");

  sw_reset_c: cover property (wr_src && bus_req_in.wdata[4] ##[1:20] $fell(sys_reset_out));
  pin_reset_c: cover property (pin_lvl ##[1:20] $fell(sys_reset_out));
  power_reset_c: cover property (s_q.st == ST_RUN && power_lvl ##1 rst_pin_oe_out);
  wdog_reset_c: cover property (s_q.st == ST_RUN && ev[WDOG_BIT]);
  rtc_reset_c: cover property (s_q.st == ST_RUN && ev[RTC_BIT]);

endmodule // reset_source_supervisor

// >>> verification/reset_rail_model.sv
`timescale 1ns/1ps
module reset_rail_model (
  input wire logic pull_low_in,
  input wire logic rst_pin_oe_in,
  input wire reset_supervisor_pkg::supply_s level_in,
  output logic ext_rst_n_out,
  output reset_supervisor_pkg::supply_s supply_out
);
  import reset_supervisor_pkg::*;
  // open-drain wire with a pull-up: nobody drives it high, so a released pin reads 1
  assign ext_rst_n_out = ~(pull_low_in | rst_pin_oe_in);
  assign supply_out = level_in;
endmodule // reset_rail_model

// >>> verification/tb.sv
`timescale 1ns/1ps
module tb;
  import reset_supervisor_pkg::*;
  localparam logic [16:0] LOCK = 17'h0fc00;
  typedef struct packed {logic [7:0] w; logic [3:0] s; logic [7:0] e; logic [1:0] irq;} row_s;
  // write value, rails {dig rst, dig warn, bat rst, bat warn}, readback, {dig irq, bat irq}
  localparam row_s ROWS [6] = '{
    '{8'h80, 4'hf, 8'he0, 2'b00}, '{8'h90, 4'hb, 8'hd0, 2'b10},
    '{8'h89, 4'hf, 8'hef, 2'b00}, '{8'h89, 4'he, 8'hed, 2'b01},
    '{8'hff, 4'ha, 8'hdd, 2'b11}, '{8'h10, 4'h3, 8'h10, 2'b00}};
  // illegal flash requests: {write, read, fetch, blocked} and address
  localparam logic [20:0] FLASH_BAD [4] = '{
    {4'h8, 17'h0fc01}, {4'h4, 17'h1ffff}, {4'h2, 17'h0fc01}, {4'h5, 17'h00100}};
  logic ref_clk_in = 1'b0;
  logic rst_n_in = 1'b0;
  bus_req_s bus_req = '0;
  flash_req_s flash_req = {4'h0, 17'h0, LOCK};
  supply_s sup_cmd = 4'hf;
  supply_s supply;
  logic ext_rst_n, rst_pin, rst_pin_oe, sys_reset, dig_irq, bat_irq;
  logic wdog_off = 1'b0;
  logic [7:0] rdata, d;
  logic pull_low = 1'b0, low_power = 1'b0, system_clock_level = 1'b0, freeze = 1'b0;
  // comparator output is already settled high before its reset is ever enabled
  logic comp_out = 1'b1;
  logic comp_wake = 1'b0, kick_on = 1'b1, wdog_kick = 1'b0, rtc_alarm = 1'b0, rtc_fail = 1'b0;
  int n_fail = 0;
  int check_count = 0;
  int cyc = 0;

  reset_source_supervisor #(.CLOCK_LOSS_CYCLES(14'd20)) reset_source_supervisor_i (
    .ref_clk_in(ref_clk_in),
    .rst_n_in(rst_n_in),
    .ce_in(1'b1),
    .bus_req_in(bus_req),
    .rdata_out(rdata),
    .supply_in(supply),
    .flash_req_in(flash_req),
    .ext_rst_n_in(ext_rst_n),
    .rst_pin_out(rst_pin),
    .rst_pin_oe_out(rst_pin_oe),
    .low_power_in(low_power),
    .system_clock_level_in(system_clock_level),
    .comp_out_in(comp_out),
    .comp_wake_en_in(comp_wake),
    .wdog_kick_in(wdog_kick),
    .wdog_disable_in(wdog_off),
    .rtc_alarm_in(rtc_alarm),
    .rtc_osc_fail_in(rtc_fail),
    .sys_reset_out(sys_reset),
    .digital_warn_irq_out(dig_irq),
    .battery_warn_irq_out(bat_irq)
  );

  reset_rail_model reset_rail_model_i (
    .pull_low_in(pull_low),
    .rst_pin_oe_in(rst_pin_oe),
    .level_in(sup_cmd),
    .ext_rst_n_out(ext_rst_n),
    .supply_out(supply)
  );

  always #5 ref_clk_in = ~ref_clk_in;

  // watched clock stops when frozen; kicks every 1000 cycles keep the watchdog out of other tests
  always @(posedge ref_clk_in) begin
    cyc <= cyc + 1;
    system_clock_level <= freeze ? system_clock_level : ~system_clock_level;
    wdog_kick <= kick_on && (cyc % 1000 == 0);
  end

  task automatic end_of_test();
    if (n_fail == 0 && check_count > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
    check_count++;
    if (got !== exp) begin
      n_fail++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge ref_clk_in);
    bus_req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: v};
    @(posedge ref_clk_in);
    bus_req <= '0;
  endtask

  task automatic rd(input logic [7:0] a, output logic [7:0] v);
    @(posedge ref_clk_in);
    bus_req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
    @(posedge ref_clk_in);
    bus_req <= '0;
    #1;
    v = rdata;
  endtask

  task automatic flash(input logic [3:0] k, input logic [16:0] a);
    @(posedge ref_clk_in);
    flash_req <= {k, a, LOCK};
    @(posedge ref_clk_in);
    flash_req <= {4'h0, 17'h0, LOCK};
  endtask

  task automatic quiet(input int n);
    logic hit;
    hit = 1'b0;
    repeat (n) begin
      @(posedge ref_clk_in);
      #1;
      hit = hit | sys_reset;
    end
    cmp({7'h0, hit}, 8'h00);
  endtask

  task automatic wait_hi(input int n, input logic oe);
    int i;
    i = 0;
    while (sys_reset !== 1'b1 && i < n) begin
      @(posedge ref_clk_in);
      #1;
      i++;
    end
    cmp({6'h0, sys_reset, rst_pin_oe}, {6'h0, 1'b1, oe});
  endtask

  // waits for the hold stretch to end, then reads back the captured cause
  task automatic done(input logic [7:0] exp);
    int i;
    logic [7:0] r;
    i = 0;
    while (sys_reset !== 1'b0 && i < 300) begin
      @(posedge ref_clk_in);
      #1;
      i++;
    end
    cmp({6'h0, sys_reset, rst_pin_oe}, 8'h00);
    rd(RESET_SRC_ADDR, r);
    cmp(r, exp);
  endtask

  initial begin
    repeat (30000) @(posedge ref_clk_in);
    n_fail++;
    end_of_test();
  end

  initial begin
    repeat (6) @(posedge ref_clk_in);
    rst_n_in <= 1'b1;
    done(8'h02);
    rd(SUPPLY_CTRL_ADDR, d);
    cmp(d, 8'he0);
    rd(8'h00, d);
    cmp(d, 8'h00);
    foreach (ROWS[i]) begin
      wr(SUPPLY_CTRL_ADDR, ROWS[i].w);
      sup_cmd <= supply_s'(ROWS[i].s);
      repeat (3) @(posedge ref_clk_in);
      rd(SUPPLY_CTRL_ADDR, d);
      cmp(d, ROWS[i].e);
      cmp({6'h0, dig_irq, bat_irq}, {6'h0, ROWS[i].irq});
    end
    sup_cmd <= 4'hf;
    wr(SUPPLY_CTRL_ADDR, 8'h80);
    low_power <= 1'b1;
    pull_low <= 1'b1;
    wait_hi(5, 1'b0);
    pull_low <= 1'b0;
    low_power <= 1'b0;
    done(8'h01);
    // watchdog switched off by software must come back on after the next reset
    wdog_off <= 1'b1;
    @(posedge ref_clk_in);
    wdog_off <= 1'b0;
    wr(RESET_SRC_ADDR, 8'h10);
    wait_hi(5, 1'b0);
    done(8'h10);
    wr(RESET_SRC_ADDR, 8'h20);
    low_power <= 1'b1;
    comp_out <= 1'b0;
    quiet(20);
    comp_wake <= 1'b1;
    wait_hi(5, 1'b0);
    comp_out <= 1'b1;
    comp_wake <= 1'b0;
    low_power <= 1'b0;
    done(8'h20);
    wr(RESET_SRC_ADDR, 8'h04);
    freeze <= 1'b1;
    quiet(15);
    low_power <= 1'b1;
    quiet(40);
    low_power <= 1'b0;
    wait_hi(45, 1'b0);
    freeze <= 1'b0;
    done(8'h04);
    kick_on <= 1'b0;
    low_power <= 1'b1;
    quiet(3500);
    low_power <= 1'b0;
    wait_hi(3200, 1'b0);
    kick_on <= 1'b1;
    done(8'h08);
    foreach (FLASH_BAD[i]) begin
      flash(FLASH_BAD[i][20:17], FLASH_BAD[i][16:0]);
      wait_hi(5, 1'b0);
      done(8'h40);
    end
    flash(4'h4, LOCK);
    flash(4'h8, 17'h00100);
    quiet(10);
    wr(SUPPLY_CTRL_ADDR, 8'h00);
    flash(4'h8, 17'h00100);
    wait_hi(5, 1'b0);
    done(8'h40);
    wr(SUPPLY_CTRL_ADDR, 8'h80);
    for (int i = 0; i < 2; i++) begin
      wr(RESET_SRC_ADDR, 8'h80);
      low_power <= (i == 0);
      @(posedge ref_clk_in);
      rtc_alarm <= (i == 0);
      rtc_fail <= (i == 1);
      @(posedge ref_clk_in);
      rtc_alarm <= 1'b0;
      rtc_fail <= 1'b0;
      wait_hi(5, 1'b0);
      low_power <= 1'b0;
      done(8'h80);
    end
    wr(RESET_SRC_ADDR, 8'h02);
    sup_cmd <= 4'h7;
    wait_hi(5, 1'b1);
    cmp({7'h0, ext_rst_n}, 8'h00);
    cmp({7'h0, rst_pin}, 8'h00);
    repeat (5) @(posedge ref_clk_in);
    sup_cmd <= 4'hf;
    done(8'h02);
    rst_n_in <= 1'b0;
    repeat (2) @(posedge ref_clk_in);
    #1;
    cmp({6'h0, sys_reset, rst_pin_oe}, 8'h03);
    @(posedge ref_clk_in);
    rst_n_in <= 1'b1;
    done(8'h02);
    end_of_test();
  end
endmodule // tb
